// ### rtl/rgfl_consts.vh
// Constants for the receive gain and frequency loops block.
// Assumes inclusion by rgfl_top.v only; definitions, no logic.
`ifndef RGFL_CONSTS_VH
`define RGFL_CONSTS_VH
// ----------------------------------------
// Register word indices (AXI address bits 5:2)
// ----------------------------------------
`define RGFL_OFF_FGAIN   4'h0
`define RGFL_OFF_FPER    4'h1
`define RGFL_OFF_FMODE   4'h2
`define RGFL_OFF_SSTHR   4'h3
`define RGFL_OFF_GHI     4'h4
`define RGFL_OFF_GTIM    4'h5
`define RGFL_OFF_GLO     4'h6
`define RGFL_OFF_FERR    4'h7
`define RGFL_OFF_STAT    4'h8
// ----------------------------------------
// Field positions
// ----------------------------------------
`define RGFL_SLOWG_LSB   0
`define RGFL_FASTG_LSB   4
`define RGFL_FEN_BIT     0
`define RGFL_FMODE_BIT   1
`define RGFL_MEAS_LSB    0
`define RGFL_HOLD_LSB    8
`define RGFL_GEN_BIT     16
`define RGFL_FRZ_BIT     17
`define RGFL_LO0_LSB     0
`define RGFL_LO1_LSB     4
`define RGFL_LOSEL_LSB   8
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RGFL_RST_MEAS    4'h2
`define RGFL_RST_ZERO    32'h0000_0000
`define RGFL_TICK_CLKS   21'h00000c
`define RGFL_MAX_STEP    4'h8
`define RGFL_LEAK_SHIFT  6
`define RGFL_RESP_OKAY   2'h0
`define RGFL_RESP_SLVERR 2'h2
`endif

// ### rtl/rgfl_top.v
// Receive gain loop and frequency compensation loop with AXI4-Lite registers.
// Assumes datapath inputs are on sys_clk_i; attenuation step drives the RF chain.
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "rgfl_consts.vh"

module rgfl_top (
   input  wire        sys_clk_i,
   input  wire        reset_i,
   input  wire [31:0] s_axi_awaddr_i,
   input  wire        s_axi_awvalid_i,
   output wire        s_axi_awready_o,
   input  wire [31:0] s_axi_wdata_i,
   input  wire [3:0]  s_axi_wstrb_i,
   input  wire        s_axi_wvalid_i,
   output wire        s_axi_wready_o,
   output wire [1:0]  s_axi_bresp_o,
   output wire        s_axi_bvalid_o,
   input  wire        s_axi_bready_i,
   input  wire [31:0] s_axi_araddr_i,
   input  wire        s_axi_arvalid_i,
   output wire        s_axi_arready_o,
   output wire [31:0] s_axi_rdata_o,
   output wire [1:0]  s_axi_rresp_o,
   output wire        s_axi_rvalid_o,
   input  wire        s_axi_rready_i,
   input  wire        rx_start_i,
   input  wire        mod_is_fsk_i,
   input  wire [7:0]  rssi_i,
   input  wire        sample_valid_i,
   input  wire [15:0] demod_freq_i,
   input  wire        sync_det_i,
   input  wire        amp_valid_i,
   input  wire [3:0]  amp_peak_i,
   output wire [15:0] slicer_offset_o,
   output wire [15:0] if2_adjust_o,
   output wire [3:0]  rf_atten_step_o
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Byte-lane merge for AXI write strobes
   function [31:0] merge_strb;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  strb;
      integer i;
      begin
         merge_strb = old_v;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge_strb[8*i +: 8] = new_v[8*i +: 8];
            end
         end
      end
   endfunction

   // Peak detector leak: moves a held peak a fraction toward the sample
   function [15:0] leak_toward;
      input signed [15:0] pk;
      input signed [15:0] x;
      reg signed [16:0] d;
      begin
         d = $signed({pk[15], pk} - {x[15], x}) >>> `RGFL_LEAK_SHIFT;
         leak_toward = pk - d[15:0];
      end
   endfunction

   // Saturate an 18-bit signed sum into 16 bits
   function [15:0] sat16;
      input signed [17:0] v;
      begin
         if (v > 18'sh07fff) begin
            sat16 = 16'h7fff;
         end else if (v < -18'sh08000) begin
            sat16 = 16'h8000;
         end else begin
            sat16 = v[15:0];
         end
      end
   endfunction

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   reg [7:0]  fgain_r;
   reg [7:0]  fper_r;
   reg [1:0]  fmode_r;
   reg [7:0]  ssthr_r;
   reg [3:0]  ghi_r;
   reg [3:0]  meas_r;
   reg [5:0]  hold_r;
   reg        gen_r;
   reg        frz_en_r;
   reg [15:0] glo_r;
   reg        awready_r;
   reg        wready_r;
   reg        bvalid_r;
   reg [1:0]  bresp_r;
   reg        arready_r;
   reg        rvalid_r;
   reg [31:0] rdata_r;
   reg [1:0]  rresp_r;
   reg [3:0]  awidx_r;
   reg        awok_r;
   reg [31:0] wdata_r;
   reg [3:0]  wstrb_r;

   // Frequency loop state
   localparam [2:0] FL_IDLE = 3'b001;
   localparam [2:0] FL_FAST = 3'b010;
   localparam [2:0] FL_SLOW = 3'b100;
   reg [2:0]         fl_state_r;
   reg [7:0]         fl_cnt_r;
   reg signed [15:0] est_r;
   reg signed [15:0] fmax_r;
   reg signed [15:0] fmin_r;
   reg [15:0]        slicer_r;
   reg [15:0]        if2_r;

   // Gain loop state
   localparam [1:0] GL_HOLD = 2'b01;
   localparam [1:0] GL_MEAS = 2'b10;
   reg [1:0]  gl_state_r;
   reg [20:0] gl_cnt_r;
   reg        below_r;
   reg        frozen_r;
   reg [3:0]  atten_r;

   wire [31:0] fmode_w = {30'h0, fmode_r};
   wire [31:0] gtim_w  = {14'h0, frz_en_r, gen_r, 2'h0, hold_r, 4'h0, meas_r};
   wire [31:0] stat_w  = {25'h0, fl_state_r != FL_IDLE, fl_state_r == FL_FAST,
                          frozen_r, atten_r};

   // ----------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------
   wire aw_hs  = s_axi_awvalid_i & awready_r;
   wire w_hs   = s_axi_wvalid_i & wready_r;
   wire wr_go  = ~awready_r & ~wready_r & ~bvalid_r;
   wire [3:0] aw_idx = s_axi_awaddr_i[5:2];
   wire aw_map = (s_axi_awaddr_i[31:6] == 26'h0) && (aw_idx <= `RGFL_OFF_GLO);
   wire [31:0] gtim_m = merge_strb(gtim_w, wdata_r, wstrb_r);
   wire [31:0] glo_m  = merge_strb({16'h0, glo_r}, wdata_r, wstrb_r);

   // Address and data are taken in any order; response after both
   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         bvalid_r  <= 1'b0;
         bresp_r   <= `RGFL_RESP_OKAY;
         awidx_r   <= 4'h0;
         awok_r    <= 1'b0;
         wdata_r   <= `RGFL_RST_ZERO;
         wstrb_r   <= 4'h0;
      end else begin
         if (aw_hs) begin
            awready_r <= 1'b0;
            awidx_r   <= aw_idx;
            awok_r    <= aw_map;
         end
         if (w_hs) begin
            wready_r <= 1'b0;
            wdata_r  <= s_axi_wdata_i;
            wstrb_r  <= s_axi_wstrb_i;
         end
         if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= awok_r ? `RGFL_RESP_OKAY : `RGFL_RESP_SLVERR;
         end else if (bvalid_r & s_axi_bready_i) begin
            bvalid_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
      end
   end

   // Configuration writes; read-only words ignore writes
   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         fgain_r  <= 8'h00;
         fper_r   <= 8'h00;
         fmode_r  <= 2'h0;
         ssthr_r  <= 8'h00;
         ghi_r    <= 4'h0;
         meas_r   <= `RGFL_RST_MEAS;
         hold_r   <= 6'h00;
         gen_r    <= 1'b0;
         frz_en_r <= 1'b0;
         glo_r    <= 16'h0000;
      end else if (wr_go & awok_r) begin
         case (awidx_r)
            `RGFL_OFF_FGAIN: fgain_r <= wstrb_r[0] ? wdata_r[7:0] : fgain_r;
            `RGFL_OFF_FPER:  fper_r  <= wstrb_r[0] ? wdata_r[7:0] : fper_r;
            `RGFL_OFF_FMODE: fmode_r <= wstrb_r[0] ? wdata_r[1:0] : fmode_r;
            `RGFL_OFF_SSTHR: ssthr_r <= wstrb_r[0] ? wdata_r[7:0] : ssthr_r;
            `RGFL_OFF_GHI:   ghi_r   <= wstrb_r[0] ? wdata_r[3:0] : ghi_r;
            `RGFL_OFF_GTIM: begin
               meas_r   <= gtim_m[`RGFL_MEAS_LSB +: 4];
               hold_r   <= gtim_m[`RGFL_HOLD_LSB +: 6];
               gen_r    <= gtim_m[`RGFL_GEN_BIT];
               frz_en_r <= gtim_m[`RGFL_FRZ_BIT];
            end
            `RGFL_OFF_GLO:   glo_r <= glo_m[15:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------
   wire [3:0] ar_idx = s_axi_araddr_i[5:2];
   wire ar_map = (s_axi_araddr_i[31:6] == 26'h0) && (ar_idx <= `RGFL_OFF_STAT);

   // One read at a time; data registered one cycle after address
   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= `RGFL_RST_ZERO;
         rresp_r   <= `RGFL_RESP_OKAY;
      end else if (s_axi_arvalid_i & arready_r) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rresp_r   <= ar_map ? `RGFL_RESP_OKAY : `RGFL_RESP_SLVERR;
         case (ar_idx)
            `RGFL_OFF_FGAIN: rdata_r <= {24'h0, fgain_r};
            `RGFL_OFF_FPER:  rdata_r <= {24'h0, fper_r};
            `RGFL_OFF_FMODE: rdata_r <= fmode_w;
            `RGFL_OFF_SSTHR: rdata_r <= {24'h0, ssthr_r};
            `RGFL_OFF_GHI:   rdata_r <= {28'h0, ghi_r};
            `RGFL_OFF_GTIM:  rdata_r <= gtim_w;
            `RGFL_OFF_GLO:   rdata_r <= {16'h0, glo_r};
            `RGFL_OFF_FERR:  rdata_r <= {{16{est_r[15]}}, est_r};
            `RGFL_OFF_STAT:  rdata_r <= stat_w;
            default:         rdata_r <= `RGFL_RST_ZERO;
         endcase
      end else if (rvalid_r & s_axi_rready_i) begin
         rvalid_r  <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   // ----------------------------------------
   // Frequency compensation loop
   // ----------------------------------------
   wire fl_run = fmode_r[`RGFL_FEN_BIT] & mod_is_fsk_i;
   wire [3:0] fl_gain = (fl_state_r == FL_FAST) ? fgain_r[7:4] : fgain_r[3:0];
   wire signed [15:0] x_w = demod_freq_i;
   wire signed [16:0] mid_w = $signed({fmax_r[15], fmax_r} + {fmin_r[15], fmin_r}) >>> 1;
   wire signed [16:0] err_w = mid_w - {est_r[15], est_r};
   wire signed [16:0] step_w = err_w >>> fl_gain;
   wire [15:0] est_nxt = sat16({step_w[16], step_w} + {{2{est_r[15]}}, est_r});

   // Peak tracking and loop filter; leaving the run condition clears the estimate
   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         fl_state_r <= FL_IDLE;
         fl_cnt_r   <= 8'h00;
         est_r      <= 16'h0000;
         fmax_r     <= 16'h0000;
         fmin_r     <= 16'h0000;
      end else if (~fl_run | rx_start_i) begin
         fl_state_r <= FL_IDLE;
         fl_cnt_r   <= 8'h00;
         est_r      <= 16'h0000;
      end else begin
         case (fl_state_r)
            FL_IDLE: begin
               if (rssi_i > ssthr_r) begin
                  fl_state_r <= FL_FAST;
                  fmax_r     <= est_r;
                  fmin_r     <= est_r;
               end
            end
            FL_FAST: begin
               // Zero period hands over at sync instead of a sample count
               if (fper_r == 8'h00) begin
                  if (sync_det_i) begin
                     fl_state_r <= FL_SLOW;
                  end
               end else if (sample_valid_i) begin
                  fl_cnt_r <= fl_cnt_r + 8'h01;
                  if (fl_cnt_r + 8'h01 >= fper_r) begin
                     fl_state_r <= FL_SLOW;
                  end
               end
            end
            FL_SLOW: fl_state_r <= FL_SLOW; // Slow gain holds until restart
            default: fl_state_r <= FL_IDLE;
         endcase
         if (sample_valid_i && fl_state_r != FL_IDLE) begin
            fmax_r <= (x_w > fmax_r) ? x_w : leak_toward(fmax_r, x_w);
            fmin_r <= (x_w < fmin_r) ? x_w : leak_toward(fmin_r, x_w);
            est_r  <= est_nxt;
         end
      end
   end

   // Route the correction to one point only, the other reads zero
   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         slicer_r <= 16'h0000;
         if2_r    <= 16'h0000;
      end else begin
         slicer_r <= fmode_r[`RGFL_FMODE_BIT] ? 16'h0000 : est_r;
         if2_r    <= fmode_r[`RGFL_FMODE_BIT] ? est_r : 16'h0000;
      end
   end

   // ----------------------------------------
   // Automatic gain loop
   // ----------------------------------------
   wire [2:0]  sel_idx  = (atten_r > 4'h7) ? 3'h7 : atten_r[2:0];
   wire        sel_bit  = glo_r[`RGFL_LOSEL_LSB + sel_idx];
   wire [3:0]  lo_thr   = sel_bit ? glo_r[7:4] : glo_r[3:0];
   wire [20:0] meas_len = `RGFL_TICK_CLKS << meas_r;
   wire [20:0] hold_len = `RGFL_TICK_CLKS * {15'h0, hold_r};
   wire [20:0] cnt_inc  = gl_cnt_r + 21'h000001;
   wire        above_hi = amp_valid_i & (amp_peak_i > ghi_r);
   wire        not_low  = amp_valid_i & (amp_peak_i >= lo_thr);

   // Hold after every change, then measure; high level skips the measure
   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         gl_state_r <= GL_HOLD;
         gl_cnt_r   <= 21'h000000;
         below_r    <= 1'b1;
         frozen_r   <= 1'b0;
         atten_r    <= 4'h0;
      end else if (~gen_r) begin
         gl_state_r <= GL_HOLD;
         gl_cnt_r   <= 21'h000000;
         frozen_r   <= 1'b0;
         atten_r    <= 4'h0;
      end else if (rx_start_i) begin
         gl_state_r <= GL_HOLD;
         gl_cnt_r   <= 21'h000000;
         frozen_r   <= 1'b0;
      end else if (frozen_r | (frz_en_r & sync_det_i)) begin
         frozen_r <= 1'b1;
      end else begin
         case (gl_state_r)
            GL_HOLD: begin
               gl_cnt_r <= cnt_inc;
               if (cnt_inc >= hold_len) begin
                  gl_state_r <= GL_MEAS;
                  gl_cnt_r   <= 21'h000000;
                  below_r    <= 1'b1;
               end
            end
            GL_MEAS: begin
               gl_cnt_r <= cnt_inc;
               if (not_low) begin
                  below_r <= 1'b0;
               end
               if (above_hi && atten_r < `RGFL_MAX_STEP) begin
                  atten_r    <= atten_r + 4'h1;
                  gl_state_r <= GL_HOLD;
                  gl_cnt_r   <= 21'h000000;
               end else if (cnt_inc >= meas_len) begin
                  gl_cnt_r <= 21'h000000;
                  below_r  <= 1'b1;
                  if (below_r && !not_low && atten_r != 4'h0) begin
                     atten_r    <= atten_r - 4'h1;
                     gl_state_r <= GL_HOLD;
                  end
                  // Between thresholds: keep attenuation, measure again
               end
            end
            default: gl_state_r <= GL_HOLD;
         endcase
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign s_axi_awready_o = awready_r;
   assign s_axi_wready_o  = wready_r;
   assign s_axi_bvalid_o  = bvalid_r;
   assign s_axi_bresp_o   = bresp_r;
   assign s_axi_arready_o = arready_r;
   assign s_axi_rvalid_o  = rvalid_r;
   assign s_axi_rdata_o   = rdata_r;
   assign s_axi_rresp_o   = rresp_r;
   assign slicer_offset_o = slicer_r;
   assign if2_adjust_o    = if2_r;
   assign rf_atten_step_o = atten_r;

endmodule
`default_nettype wire

// ### testbench/rgfl_monitor.sv
// Checker for the receive gain and frequency loops block.
// Assumes it is bound into rgfl_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module rgfl_monitor (
   input wire logic        sys_clk_i,
   input wire logic        reset_i,
   input wire logic        s_axi_awvalid_i,
   input wire logic        s_axi_awready_o,
   input wire logic        s_axi_wvalid_i,
   input wire logic        s_axi_wready_o,
   input wire logic        s_axi_bvalid_o,
   input wire logic        s_axi_arvalid_i,
   input wire logic        s_axi_arready_o,
   input wire logic        s_axi_rvalid_o,
   input wire logic        s_axi_rready_i,
   input wire logic        mod_is_fsk_i,
   input wire logic        amp_valid_i,
   input wire logic [15:0] slicer_offset_o,
   input wire logic [15:0] if2_adjust_o,
   input wire logic [3:0]  rf_atten_step_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   logic [3:0] prev_r;
   logic [7:0] quiet_r;
   // -------
   // Step history
   // -------
   // Counts cycles the step stood still; a decrease must follow a full measure
   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         prev_r  <= 4'h0;
         quiet_r <= 8'h00;
      end else begin
         prev_r  <= rf_atten_step_o;
         quiet_r <= (rf_atten_step_o != prev_r) ? 8'h00 : quiet_r + {7'h0, quiet_r != 8'hff};
      end
   end
   AST_ATTEN_MAX: assert property (rf_atten_step_o <= 4'h8)
      else $error("attenuation step above eight");
   AST_ONE_STEP: assert property ((rf_atten_step_o != prev_r) |->
      (rf_atten_step_o == prev_r + 4'h1 || rf_atten_step_o + 4'h1 == prev_r))
      else $error("attenuation moved by more than one step");
   AST_INC_ON_AMP: assert property ((rf_atten_step_o > prev_r) |-> $past(amp_valid_i))
      else $error("increase without a peak sample");
   AST_DEC_AFTER_MEASURE: assert property ((rf_atten_step_o < prev_r) |-> quiet_r >= 8'd12)
      else $error("decrease without a full measure interval");
   AST_INC_SPACED: assert property ((rf_atten_step_o > prev_r) |-> quiet_r >= 8'd1)
      else $error("increase inside the hold interval");
   AST_FSK_OFF_ZERO: assert property ((!mod_is_fsk_i) [*2] |=>
      (slicer_offset_o == 16'h0 && if2_adjust_o == 16'h0))
      else $error("correction while not in frequency modulation");
   AST_ONE_CORR_PATH: assert property (!(slicer_offset_o != 16'h0 && if2_adjust_o != 16'h0))
      else $error("correction applied on both paths");
   AST_WRITE_ANSWER: assert property ((s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
      && s_axi_wready_o) |=> !s_axi_awready_o ##1 (s_axi_bvalid_o && !s_axi_awready_o))
      else $error("write response missing");
   AST_READ_ANSWER: assert property ((s_axi_arvalid_i && s_axi_arready_o) |=>
      (s_axi_rvalid_o && !s_axi_arready_o))
      else $error("read data missing");
   AST_READY_BACK: assert property ((s_axi_rvalid_o && s_axi_rready_i) |=>
      (s_axi_arready_o && !s_axi_rvalid_o))
      else $error("read channel not released");
endmodule
bind rgfl_top rgfl_monitor u_mon (
   .sys_clk_i(sys_clk_i), .reset_i(reset_i), .s_axi_awvalid_i(s_axi_awvalid_i),
   .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
   .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
   .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
   .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
   .mod_is_fsk_i(mod_is_fsk_i), .amp_valid_i(amp_valid_i),
   .slicer_offset_o(slicer_offset_o), .if2_adjust_o(if2_adjust_o),
   .rf_atten_step_o(rf_atten_step_o));
`default_nettype wire

// ### testbench/rgfl_rf_model.sv
// Model of the analog receive chain and demodulator feeding the loops.
// Assumes the loops' clock; peak drops one code per attenuation step.
`timescale 1ns/100ps
`default_nettype none
module rgfl_rf_model (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic [3:0]  level_i,
   input  wire logic [15:0] offset_i,
   input  wire logic [3:0]  atten_i,
   output var  logic        amp_valid_o,
   output var  logic [3:0]  amp_peak_o,
   output var  logic        sample_valid_o,
   output var  logic [15:0] demod_freq_o
);
   logic [1:0] ph_r;
   logic       hi_r;
   logic [3:0] peak_nxt;
   // -------
   // Chain
   // -------
   // Linear stand-in for the chain: each step removes one code of peak
   assign peak_nxt = (level_i > atten_i) ? level_i - atten_i : 4'h0;
   // Lines between strobes carry inverted junk so stale values never pass
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ph_r           <= 2'h0;
         hi_r           <= 1'b0;
         amp_valid_o    <= 1'b0;
         amp_peak_o     <= 4'h0;
         sample_valid_o <= 1'b0;
         demod_freq_o   <= 16'h0;
      end else begin
         ph_r           <= ph_r + 2'h1;
         amp_valid_o    <= (ph_r == 2'h3);
         amp_peak_o     <= (ph_r == 2'h3) ? peak_nxt : ~amp_peak_o;
         sample_valid_o <= (ph_r == 2'h1);
         hi_r           <= hi_r ^ (ph_r == 2'h1);
         demod_freq_o   <= (ph_r != 2'h1) ? ~demod_freq_o :
                           hi_r ? offset_i + 16'd300 : offset_i - 16'd300;
      end
   end
endmodule
`default_nettype wire

// ### testbench/tb_rx_gain_and_freq_loops.sv
// Testbench for the receive gain and frequency loops block.
// Assumes rgfl_top, rgfl_rf_model and the bound checker; one 40 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module tb_rx_gain_and_freq_loops;
   logic        clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
   logic        rxs = 0, fsk = 0, syn = 0;
   logic [31:0] awa = 0, wd = 0, ara = 0, rd, d;
   logic [7:0]  rssi = 0;
   logic [3:0]  lvl = 0, prv = 0;
   logic [15:0] off = 0;
   logic [1:0]  rs;
   wire logic   aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, amp_v, smp_v;
   wire logic [1:0]  b_rsp, r_rsp;
   wire logic [31:0] r_dat;
   wire logic [3:0]  amp_p, att;
   wire logic [15:0] dfq, slc, if2;
   int          errors = 0, compares = 0, cyc = 0, tl = 0, ldir = 0, gmin, gmax, H, M;
   localparam logic [31:0] RM [7] = '{32'hff, 32'hff, 32'h3, 32'hff, 32'hf, 32'h2_3f0f, 32'hffff};
   rgfl_top dut (
      .sys_clk_i(clk), .reset_i(rst),
      .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(aw_rdy),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(w_rdy),
      .s_axi_bresp_o(b_rsp), .s_axi_bvalid_o(b_vld), .s_axi_bready_i(bre),
      .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(ar_rdy),
      .s_axi_rdata_o(r_dat), .s_axi_rresp_o(r_rsp), .s_axi_rvalid_o(r_vld), .s_axi_rready_i(rre),
      .rx_start_i(rxs), .mod_is_fsk_i(fsk), .rssi_i(rssi), .sample_valid_i(smp_v),
      .demod_freq_i(dfq), .sync_det_i(syn), .amp_valid_i(amp_v), .amp_peak_i(amp_p),
      .slicer_offset_o(slc), .if2_adjust_o(if2), .rf_atten_step_o(att));
   rgfl_rf_model u_rf (
      .clk_i(clk), .reset_i(rst), .level_i(lvl), .offset_i(off), .atten_i(att),
      .amp_valid_o(amp_v), .amp_peak_o(amp_p), .sample_valid_o(smp_v), .demod_freq_o(dfq));
   // -------
   // Helpers
   // -------
   initial begin
      forever #12.5 clk = ~clk;
   end
   // Gap between two step changes of the same direction, in cycles
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (att !== prv) begin
         if (((att > prv) ? 1 : 2) == ldir) begin
            gmin = (cyc - tl < gmin) ? cyc - tl : gmin;
            gmax = (cyc - tl > gmax) ? cyc - tl : gmax;
         end
         ldir = (att > prv) ? 1 : 2;
         tl = cyc;
         prv = att;
      end
   end
   function automatic int gap_lo(input bit dec);
      return 12 * H + (dec ? (12 << M) : 0);
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic near(input string n, input logic signed [31:0] e, input logic signed [31:0] s);
      compares++;
      if ((s - e <= 40 && e - s <= 40) !== 1'b1) begin
         errors++;
         $display("BAD %s expected %0d seen %0d", n, e, s);
      end
   endtask
   task automatic rng(input string n, input int lo, input int hi, input int v);
      compares++;
      if (v < lo || v > hi) begin
         errors++;
         $display("BAD %s expected %0d..%0d seen %0d", n, lo, hi, v);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
      @(posedge clk);
      awa <= {24'h0, a};
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      do begin
         @(posedge clk);
         if (aw_rdy === 1'b1) awv <= 1'b0;
         if (w_rdy === 1'b1) wv <= 1'b0;
      end while (b_vld !== 1'b1);
      r = b_rsp;
      bre <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      @(posedge clk);
      ara <= {24'h0, a};
      arv <= 1'b1;
      rre <= 1'b1;
      do begin
         @(posedge clk);
         if (ar_rdy === 1'b1) arv <= 1'b0;
      end while (r_vld !== 1'b1);
      v = r_dat;
      r = r_rsp;
      rre <= 1'b0;
   endtask
   task automatic pulse(input bit s);
      @(posedge clk);
      if (s) syn <= 1'b1;
      else rxs <= 1'b1;
      @(posedge clk);
      syn <= 1'b0;
      rxs <= 1'b0;
   endtask
   task automatic settle(input logic [3:0] e);
      for (int k = 0; k < 4000 && att !== e; k++) @(posedge clk);
      chk("atten", {28'h0, e}, {28'h0, att});
   endtask
   task automatic clr;
      @(negedge clk);
      ldir = 0;
      gmin = 99999;
      gmax = 0;
   endtask
   task automatic give_verdict;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      void'($urandom(40284));
      H = 2 + $urandom_range(2);
      M = $urandom_range(2);
      idle(6);
      rst <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         rdr(8'(4 * i), rd, rs);
         chk("reset value", (i == 5) ? 32'h2 : 32'h0, rd);
         chk("read resp", (i == 9) ? 32'h2 : 32'h0, {30'h0, rs});
      end
      for (int i = 0; i < 7; i++) begin
         d = $urandom();
         wr(8'(4 * i), d & ((i == 5) ? 32'h2_3f0f : 32'hffff_ffff), rs);
         rdr(8'(4 * i), rd, rs);
         chk("read back", d & RM[i], rd);
      end
      wr(8'h24, 32'h1, rs);
      chk("unmapped write", 32'h2, {30'h0, rs});
      $display("test registers done");
      wr(8'h10, 32'h5, rs);
      wr(8'h18, 32'h1045, rs);
      wr(8'h14, (H << 8) | M, rs);
      lvl <= 4'hf;
      idle(100);
      chk("atten off", 32'h0, {28'h0, att});
      wr(8'h14, 32'h1_0000 | (H << 8) | M, rs);
      clr();
      settle(4'h8);
      rng("inc gap", gap_lo(0), gap_lo(0) + 8, gmin);
      rng("inc gap", gap_lo(0), gap_lo(0) + 8, gmax);
      idle(200);
      chk("atten max", 32'h8, {28'h0, att});
      lvl <= 4'hc;
      settle(4'h7);
      idle(300);
      chk("atten kept", 32'h7, {28'h0, att});
      clr();
      lvl <= 4'h8;
      settle(4'h4);
      rng("dec gap", gap_lo(1), gap_lo(1) + 8, gmin);
      rng("dec gap", gap_lo(1), gap_lo(1) + 8, gmax);
      wr(8'h14, 32'h3_0000 | (H << 8) | M, rs);
      pulse(1);
      lvl <= 4'hf;
      idle(400);
      chk("atten frozen", 32'h4, {28'h0, att});
      pulse(0);
      settle(4'h8);
      $display("test gain loop done");
      off <= 16'($urandom_range(800)) - 16'd400;
      wr(8'h00, 32'h42, rs);
      wr(8'h04, 32'h0, rs);
      wr(8'h0c, 32'h40, rs);
      wr(8'h08, 32'h1, rs);
      fsk <= 1'b1;
      rssi <= 8'h10;
      idle(200);
      rdr(8'h1c, rd, rs);
      chk("estimate idle", 32'h0, rd);
      rssi <= 8'h80;
      idle(1000);
      rdr(8'h20, rd, rs);
      chk("fast flag", 32'h1, {31'h0, rd[5]});
      rdr(8'h1c, rd, rs);
      near("estimate", {{16{off[15]}}, off}, rd);
      near("slicer", {{16{off[15]}}, off}, {{16{slc[15]}}, slc});
      chk("if2 idle", 32'h0, {16'h0, if2});
      pulse(1);
      idle(5);
      rdr(8'h20, rd, rs);
      chk("slow after sync", 32'h0, {31'h0, rd[5]});
      wr(8'h08, 32'h3, rs);
      idle(10);
      near("if2", {{16{off[15]}}, off}, {{16{if2[15]}}, if2});
      chk("slicer idle", 32'h0, {16'h0, slc});
      fsk <= 1'b0;
      idle(10);
      rdr(8'h1c, rd, rs);
      chk("estimate no fsk", 32'h0, rd | {16'h0, if2});
      fsk <= 1'b1;
      wr(8'h04, 32'h8, rs);
      pulse(0);
      idle(2);
      rdr(8'h20, rd, rs);
      chk("fast start", 32'h1, {31'h0, rd[5]});
      idle(200);
      rdr(8'h20, rd, rs);
      chk("slow after period", 32'h0, {31'h0, rd[5]});
      wr(8'h08, 32'h2, rs);
      idle(10);
      rdr(8'h1c, rd, rs);
      chk("estimate disabled", 32'h0, rd);
      $display("test frequency loop done");
      give_verdict();
   end
   // Cut a hang short; the sequence needs well under half of this span
   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      $display("BAD watchdog expected finish seen hang");
      give_verdict();
   end
endmodule
`default_nettype wire
